// ===== cbu_dec_if.sv
`timescale 1ns/1ps
// decode request and result between the unit and its decoder
interface cbu_dec_if;
   logic [15:0] word;
   logic [31:0] acc;
   logic overflow_flag;
   logic [1:0] dest;
   logic pe;
   logic [cbu_pkg::CBU_PW_W-1:0] pw;
   logic hit;
   logic [4:0] kind;
   logic taken;
   logic [7:0] cycles;

   modport dec (input word, acc, overflow_flag, dest, pe, pw, output hit, kind, taken, cycles);
   modport use_side (output word, acc, overflow_flag, dest, pe, pw, input hit, kind, taken, cycles);
endinterface

// ===== cbu_decode.sv
`timescale 1ns/1ps
module cbu_decode
(
   // decode request and result
   cbu_dec_if.dec d
);
   logic [7:0] p8;
   logic [7:0] base;
   logic [7:0] fetch;

   // kind from opcode; branches ignore their indirect field bits
   always_comb
   begin
      d.kind = 5'h00;
      if ((d.word & cbu_pkg::CBU_BR_MASK) == cbu_pkg::CBU_OP_NZ)
         d.kind = cbu_pkg::CBU_K_NZ;
      else if ((d.word & cbu_pkg::CBU_BR_MASK) == cbu_pkg::CBU_OP_Z)
         d.kind = cbu_pkg::CBU_K_Z;
      else if ((d.word & cbu_pkg::CBU_BR_MASK) == cbu_pkg::CBU_OP_V)
         d.kind = cbu_pkg::CBU_K_V;
      else if ((d.word & cbu_pkg::CBU_BR_MASK) == cbu_pkg::CBU_OP_NV)
         d.kind = cbu_pkg::CBU_K_NV;
      else if (d.word == cbu_pkg::CBU_OP_CALL)
         d.kind = cbu_pkg::CBU_K_CALL;
      d.hit = (d.kind != 5'h00);
   end

   // branch conditions; the call always transfers
   always_comb
   begin
      case (d.kind)
         cbu_pkg::CBU_K_NZ: d.taken = (d.acc != 32'h0000_0000);
         cbu_pkg::CBU_K_Z: d.taken = (d.acc == 32'h0000_0000);
         cbu_pkg::CBU_K_V: d.taken = d.overflow_flag;
         cbu_pkg::CBU_K_NV: d.taken = !d.overflow_flag;
         default: d.taken = 1'b1;
      endcase
   end

   // cycle cost: base by destination plus external fetch penalty
   always_comb
   begin
      p8 = {4'h0, d.pw};
      case (d.dest)
         cbu_pkg::CBU_MEM_ROM: base = cbu_pkg::CBU_CYC_ROM;
         cbu_pkg::CBU_MEM_EXT: base = 8'(cbu_pkg::CBU_CYC_EXT + p8);
         default: base = cbu_pkg::CBU_CYC_RAM;
      endcase
      if (!d.taken)
         base = cbu_pkg::CBU_CYC_FALSE;
      // the call fetches once from slow memory, a branch twice
      fetch = (d.kind == cbu_pkg::CBU_K_CALL) ? p8 : 8'(p8 << 1);
      d.cycles = d.pe ? 8'(base + fetch) : base;
   end
endmodule

// ===== cbu_pkg.sv
package cbu_pkg;
   // opcode matching: branches compare the top nine bits, call the full word
   localparam logic [15:0] CBU_BR_MASK = 16'hFF80;
   localparam logic [15:0] CBU_OP_NZ = 16'hF580;
   localparam logic [15:0] CBU_OP_Z = 16'hF680;
   localparam logic [15:0] CBU_OP_V = 16'hF080;
   localparam logic [15:0] CBU_OP_NV = 16'hF780;
   localparam logic [15:0] CBU_OP_CALL = 16'hCE24;
   localparam int CBU_IND_W = 7;

   // one-hot instruction kinds
   localparam logic [4:0] CBU_K_NZ = 5'h01;
   localparam logic [4:0] CBU_K_Z = 5'h02;
   localparam logic [4:0] CBU_K_V = 5'h04;
   localparam logic [4:0] CBU_K_NV = 5'h08;
   localparam logic [4:0] CBU_K_CALL = 5'h10;

   // destination memory class
   localparam logic [1:0] CBU_MEM_RAM = 2'h0;
   localparam logic [1:0] CBU_MEM_ROM = 2'h1;
   localparam logic [1:0] CBU_MEM_EXT = 2'h2;

   // base cycle counts per destination, and for an untaken branch
   localparam logic [7:0] CBU_CYC_RAM = 8'h02;
   localparam logic [7:0] CBU_CYC_ROM = 8'h03;
   localparam logic [7:0] CBU_CYC_EXT = 8'h03;
   localparam logic [7:0] CBU_CYC_FALSE = 8'h02;

   // program-counter steps
   localparam logic [15:0] CBU_STEP_ONE = 16'h0001;
   localparam logic [15:0] CBU_STEP_TWO = 16'h0002;

   // register map (byte addresses)
   localparam logic [7:0] CBU_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CBU_ADDR_STATUS = 8'h04;
   localparam int CBU_CTRL_EN = 0;
   localparam int CBU_CTRL_PE = 1;
   localparam int CBU_CTRL_PW_LSB = 4;
   localparam int CBU_PW_W = 4;
   localparam int CBU_STAT_BUSY = 0;
   localparam int CBU_STAT_TAKEN = 1;
   localparam int CBU_STAT_CNT_LSB = 8;
   localparam logic CBU_RST_EN = 1'b1;

   typedef enum logic [1:0]
   {
      CBU_ST_IDLE = 2'b01,
      CBU_ST_EXEC = 2'b10
   } cbu_st_e;

   typedef struct packed
   {
      cbu_st_e st;
      logic [7:0] cnt;
      logic [4:0] kind;
      logic taken;
      logic [15:0] tgt;
      logic [15:0] ret;
      logic [15:0] acc_lo;
      logic [CBU_IND_W-1:0] ind;
      logic done;
      logic pc_load;
      logic [15:0] pc_next;
      logic push;
      logic [15:0] push_data;
      logic overflow_clr;
      logic aux_mod;
      logic [CBU_IND_W-1:0] aux_field;
      logic carry_we;
      logic rpt_clear;
      logic busy;
      logic enable;
      logic pe;
      logic [CBU_PW_W-1:0] pw;
      logic last_taken;
      logic [7:0] count;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } cbu_state_s;
endpackage

// ===== cbu_unit.sv
`timescale 1ns/1ps
module cbu_unit
(
   // clock, enable and reset
   input wire logic clock,
   input wire logic ce,
   input wire logic rst,
   // instruction issue from fetch
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [15:0] instr_arg,
   input wire logic [15:0] pc,
   input wire logic [31:0] acc,
   input wire logic overflow_flag,
   input wire logic [1:0] dest_mem,
   input wire logic rpt_active,
   // results toward pc, stack, status and aux logic
   output logic done,
   output logic pc_load,
   output logic [15:0] pc_next,
   output logic push,
   output logic [15:0] push_data,
   output logic overflow_clr,
   output logic aux_mod,
   output logic [6:0] aux_field,
   output logic carry_we,
   output logic rpt_clear,
   output logic busy,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr
);
   cbu_pkg::cbu_state_s r;
   cbu_pkg::cbu_state_s next_r;
   cbu_dec_if dif();
   logic accept;
   logic mapped;
   logic [31:0] rd_word;

   cbu_decode u_dec
   (
      .d(dif.dec)
   );

   // decoder sees the live issue word and the programmed fetch timing
   assign dif.word = instr_word;
   assign dif.acc = acc;
   assign dif.overflow_flag = overflow_flag;
   assign dif.dest = dest_mem;
   assign dif.pe = r.pe;
   assign dif.pw = r.pw;

   // a new instruction is only taken while idle and enabled
   assign accept = instr_valid && r.enable && dif.hit && (r.st == cbu_pkg::CBU_ST_IDLE);

   // register read mux; unmapped addresses answer with an error
   always_comb
   begin
      mapped = 1'b1;
      rd_word = 32'h0000_0000;
      case (paddr)
         cbu_pkg::CBU_ADDR_CTRL:
         begin
            rd_word[cbu_pkg::CBU_CTRL_EN] = r.enable;
            rd_word[cbu_pkg::CBU_CTRL_PE] = r.pe;
            rd_word[cbu_pkg::CBU_CTRL_PW_LSB +: cbu_pkg::CBU_PW_W] = r.pw;
         end
         cbu_pkg::CBU_ADDR_STATUS:
         begin
            rd_word[cbu_pkg::CBU_STAT_BUSY] = r.busy;
            rd_word[cbu_pkg::CBU_STAT_TAKEN] = r.last_taken;
            rd_word[cbu_pkg::CBU_STAT_CNT_LSB +: 8] = r.count;
         end
         default: mapped = 1'b0;
      endcase
   end

   // next state: bus slave plus the execution sequence
   always_comb
   begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.pc_load = 1'b0;
      next_r.push = 1'b0;
      next_r.overflow_clr = 1'b0;
      next_r.aux_mod = 1'b0;
      next_r.rpt_clear = 1'b0;
      next_r.carry_we = 1'b0; // carry is never touched here
      // pready rises one cycle into the access phase, then drops
      if (psel && penable && !r.pready)
      begin
         next_r.pready = 1'b1;
         next_r.pslverr = !mapped;
         next_r.prdata = mapped ? rd_word : 32'h0000_0000;
      end
      else
      begin
         next_r.pready = 1'b0;
         next_r.pslverr = 1'b0;
         // write lands at the completing edge only
         if (psel && penable && r.pready && pwrite && paddr == cbu_pkg::CBU_ADDR_CTRL)
         begin
            next_r.enable = pwdata[cbu_pkg::CBU_CTRL_EN];
            next_r.pe = pwdata[cbu_pkg::CBU_CTRL_PE];
            next_r.pw = pwdata[cbu_pkg::CBU_CTRL_PW_LSB +: cbu_pkg::CBU_PW_W];
         end
      end
      case (r.st)
         cbu_pkg::CBU_ST_IDLE:
         begin
            if (accept)
            begin
               next_r.st = cbu_pkg::CBU_ST_EXEC;
               next_r.busy = 1'b1;
               next_r.kind = dif.kind;
               next_r.taken = dif.taken;
               next_r.cnt = 8'(dif.cycles - 8'h01);
               next_r.tgt = instr_arg; // second word is the target
               next_r.ret = 16'(pc + cbu_pkg::CBU_STEP_TWO);
               next_r.acc_lo = acc[15:0]; // upper half ignored
               next_r.ind = instr_word[cbu_pkg::CBU_IND_W-1:0];
               // a repeat must not iterate these, so cancel it now
               next_r.rpt_clear = rpt_active;
               if (dif.kind == cbu_pkg::CBU_K_CALL)
               begin
                  // push happens before the redirect at done
                  next_r.push = 1'b1;
                  next_r.push_data = 16'(pc + cbu_pkg::CBU_STEP_ONE);
               end
            end
         end
         cbu_pkg::CBU_ST_EXEC:
         begin
            if (r.cnt == 8'h01)
            begin
               next_r.st = cbu_pkg::CBU_ST_IDLE;
               next_r.busy = 1'b0;
               next_r.done = 1'b1;
               next_r.pc_load = 1'b1;
               next_r.last_taken = r.taken;
               next_r.count = 8'(r.count + 8'h01);
               if (r.kind == cbu_pkg::CBU_K_CALL)
                  next_r.pc_next = r.acc_lo;
               else
               begin
                  next_r.pc_next = r.taken ? r.tgt : r.ret;
                  // aux update applies whether or not the branch is taken
                  next_r.aux_mod = 1'b1;
                  next_r.aux_field = r.ind;
               end
               next_r.overflow_clr = (r.kind == cbu_pkg::CBU_K_NV) || ((r.kind == cbu_pkg::CBU_K_V) && r.taken);
            end
            else
               next_r.cnt = 8'(r.cnt - 8'h01);
         end
         default:
         begin
            next_r.st = cbu_pkg::CBU_ST_IDLE;
            next_r.busy = 1'b0;
         end
      endcase
   end

   // one register for the whole state; rst wins, otherwise ce low freezes everything
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         r <= '0;
         r.st <= cbu_pkg::CBU_ST_IDLE;
         r.enable <= cbu_pkg::CBU_RST_EN;
      end
      else if (ce)
         r <= next_r;
   end

   // outputs straight from the state register
   assign done = r.done;
   assign pc_load = r.pc_load;
   assign pc_next = r.pc_next;
   assign push = r.push;
   assign push_data = r.push_data;
   assign overflow_clr = r.overflow_clr;
   assign aux_mod = r.aux_mod;
   assign aux_field = r.aux_field;
   assign carry_we = r.carry_we;
   assign rpt_clear = r.rpt_clear;
   assign busy = r.busy;
   assign pready = r.pready;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr;

   // checks below assume ce stays high over the window they watch
   property p_nz_taken;
      @(posedge clock) disable iff (rst)
      (ce && accept && dif.kind == cbu_pkg::CBU_K_NZ && acc != 32'h0000_0000) |=> r.taken;
   endproperty
   a_nz_taken: assert property (p_nz_taken) else $error("nonzero branch not taken");

   property p_z_fall;
      @(posedge clock) disable iff (rst)
      (r.pc_load && r.kind == cbu_pkg::CBU_K_Z && !r.taken) |-> (r.pc_next == r.ret);
   endproperty
   a_z_fall: assert property (p_z_fall) else $error("zero branch fall-through wrong");

   property p_v_clear;
      @(posedge clock) disable iff (rst)
      (r.done && r.kind == cbu_pkg::CBU_K_V) |-> (r.overflow_clr == r.taken);
   endproperty
   a_v_clear: assert property (p_v_clear) else $error("overflow clear mismatch");

   property p_nv_clear;
      @(posedge clock) disable iff (rst)
      (r.done && r.kind == cbu_pkg::CBU_K_NV) |-> r.overflow_clr;
   endproperty
   a_nv_clear: assert property (p_nv_clear) else $error("no-overflow branch left flag");

   property p_call_push;
      @(posedge clock) disable iff (rst)
      (ce && accept && dif.kind == cbu_pkg::CBU_K_CALL) |=> (r.push && r.push_data == 16'($past(pc) + 16'h0001));
   endproperty
   a_call_push: assert property (p_call_push) else $error("call push missing");

   property p_call_pc;
      @(posedge clock) disable iff (rst)
      (ce && accept && dif.kind == cbu_pkg::CBU_K_CALL && dest_mem == cbu_pkg::CBU_MEM_RAM && !r.pe)
      |-> ##2 (r.done && r.pc_next == $past(acc[15:0], 2));
   endproperty
   a_call_pc: assert property (p_call_pc) else $error("call target or timing wrong");

   property p_carry;
      @(posedge clock) disable iff (rst)
      (r.push || r.done) |-> !carry_we;
   endproperty
   a_carry: assert property (p_carry) else $error("carry written");

   property p_rpt;
      @(posedge clock) disable iff (rst)
      (ce && accept && rpt_active) |=> r.rpt_clear;
   endproperty
   a_rpt: assert property (p_rpt) else $error("repeat not cancelled");

   property p_rom_call;
      @(posedge clock) disable iff (rst)
      (ce && accept && dif.kind == cbu_pkg::CBU_K_CALL && dest_mem == cbu_pkg::CBU_MEM_ROM && !r.pe)
      |=> !r.done [*2] ##1 r.done;
   endproperty
   a_rom_call: assert property (p_rom_call) else $error("rom call not three cycles");

   property p_aux;
      @(posedge clock) disable iff (rst)
      (r.done && r.kind != cbu_pkg::CBU_K_CALL) |-> (r.aux_mod && r.aux_field == r.ind);
   endproperty
   a_aux: assert property (p_aux) else $error("aux update missing");

   property p_ret;
      @(posedge clock) disable iff (rst)
      (ce && accept && dif.kind != cbu_pkg::CBU_K_CALL) |=> (r.ret == 16'($past(pc) + 16'h0002));
   endproperty
   a_ret: assert property (p_ret) else $error("two-word return wrong");
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
   logic clock, ce, rst, instr_valid, overflow_flag, rpt_active;
   logic [15:0] instr_word, instr_arg, pc, pc_next, push_data;
   logic [31:0] acc, pwdata, prdata, rd;
   logic [1:0] dest_mem;
   logic done, pc_load, push, overflow_clr, aux_mod, carry_we, rpt_clear, busy;
   logic [6:0] aux_field;
   logic psel, penable, pwrite, pready, pslverr, er, last_tk;
   logic [7:0] paddr;
   int err_total, samples_checked, seed, cnt, pe_m, p_m;

   cbu_unit i_dut
   (
      .clock, .ce, .rst, .instr_valid, .instr_word, .instr_arg, .pc, .acc, .overflow_flag, .dest_mem,
      .rpt_active, .done, .pc_load, .pc_next, .push, .push_data, .overflow_clr, .aux_mod, .aux_field,
      .carry_we, .rpt_clear, .busy, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr
   );

   // 40 MHz core clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task print_verdict;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen high at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clock);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         err_total++;
         print_verdict;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // issue one instruction and follow it to completion against the model;
   // hold keeps ce low that many cycles after the take, which must stretch the run
   task run(input int k, input logic [1:0] dm, input logic [31:0] a, input logic ovf, input logic rp,
            input int hold);
      int i, n;
      logic tk;
      logic [15:0] w, arg, pcv;
      logic [6:0] ind;
      ind = 7'($random(seed));
      arg = 16'($random(seed));
      pcv = 16'($random(seed));
      case (k)
         0: w = cbu_pkg::CBU_OP_NZ;
         1: w = cbu_pkg::CBU_OP_Z;
         2: w = cbu_pkg::CBU_OP_V;
         3: w = cbu_pkg::CBU_OP_NV;
         default: w = cbu_pkg::CBU_OP_CALL;
      endcase
      if (k < 4)
         w = w | {9'h000, ind};
      tk = (k == 0) ? (a != 0) : (k == 1) ? (a == 0) : (k == 2) ? ovf : (k == 3) ? !ovf : 1'b1;
      n = (dm == 2'h2) ? 3 + p_m : (dm == 2'h1) ? 3 : 2;
      if (k < 4 && !tk)
         n = 2;
      n = n + ((pe_m != 0) ? ((k < 4) ? 2 * p_m : p_m) : 0) + hold;
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_word <= w;
      instr_arg <= arg;
      pc <= pcv;
      acc <= a;
      overflow_flag <= ovf;
      dest_mem <= dm;
      rpt_active <= rp;
      // taking edge
      @(posedge clock);
      // held one more cycle on long ones: a busy unit must ignore it
      instr_valid <= (n >= 3);
      ce <= (hold == 0);
      #1;
      // push and rpt_clear are one-cycle pulses, so look right after the take
      chk(32'(push), 32'(k == 4), "push");
      if (k == 4)
         chk(32'(push_data), 32'(16'(pcv + 16'h0001)), "push_data");
      chk(32'(rpt_clear), 32'(rp), "rpt_clear");
      chk(32'(busy), 32'h1, "busy");
      // i counts cycles from the taking edge, so done shows at i == n
      for (i = 2; i <= 81; i++)
      begin
         @(posedge clock);
         instr_valid <= 1'b0;
         ce <= (i > hold);
         #1;
         if (done === 1'b1)
            break;
      end
      if (i > 81)
      begin
         err_total++;
         print_verdict;
      end
      chk(32'(i), 32'(n), "cycles");
      chk(32'(pc_load), 32'h1, "pc_load");
      if (k == 4)
         chk(32'(pc_next), 32'(a[15:0]), "call target");
      else
         chk(32'(pc_next), 32'(tk ? arg : 16'(pcv + 16'h0002)), "branch pc");
      chk(32'(overflow_clr), 32'(k == 3 || (k == 2 && tk)), "overflow_clr");
      chk(32'(aux_mod), 32'(k < 4), "aux_mod");
      if (k < 4)
         chk(32'(aux_field), 32'(ind), "aux_field");
      chk(32'(carry_we), 32'h0, "carry_we");
      cnt++;
      last_tk = tk;
   endtask

   // present a request that must be ignored, then watch for silence
   task no_take(input logic [15:0] w);
      int i;
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_word <= w;
      acc <= 32'h0000_0005;
      @(posedge clock);
      instr_valid <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         @(posedge clock);
         #1;
         chk(32'(done | busy), 32'h0, "ignored request");
      end
   endtask

   // watchdog against a hung design
   initial
   begin
      #2000000;
      err_total++;
      print_verdict;
   end

   initial
   begin
      seed = 1252;
      ce = 1'b1;
      rst = 1'b1;
      {instr_valid, overflow_flag, rpt_active, psel, penable, pwrite} = 6'h00;
      {instr_word, instr_arg, pc, acc, pwdata, paddr, dest_mem} = '0;
      err_total = 0;
      samples_checked = 0;
      cnt = 0;
      pe_m = 0;
      p_m = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      // reset values, read-only status, unmapped place
      apb(1'b0, cbu_pkg::CBU_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_0001, "ctrl reset");
      apb(1'b1, cbu_pkg::CBU_ADDR_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, cbu_pkg::CBU_ADDR_STATUS, 32'h0);
      chk(rd, 32'h0, "status reset");
      apb(1'b1, 8'h08, 32'h0000_0000);
      apb(1'b0, 8'h08, 32'h0);
      chk({rd[30:0], er}, 32'h1, "unmapped");
      // disabled unit and unknown opcode are ignored
      apb(1'b1, cbu_pkg::CBU_ADDR_CTRL, 32'h0);
      no_take(cbu_pkg::CBU_OP_NZ);
      apb(1'b1, cbu_pkg::CBU_ADDR_CTRL, 32'h1);
      no_take(16'h1234);
      // every kind and destination; fetch penalty off, then on with p at 2 and at 15
      for (int c = 0; c < 3; c++)
      begin
         pe_m = (c != 0);
         p_m = (c == 1) ? 2 : (c == 2) ? 15 : 0;
         apb(1'b1, cbu_pkg::CBU_ADDR_CTRL, {24'h0, 4'(p_m), 2'b00, 1'(pe_m), 1'b1});
         apb(1'b0, cbu_pkg::CBU_ADDR_CTRL, 32'h0);
         chk(rd, {24'h0, 4'(p_m), 2'b00, 1'(pe_m), 1'b1}, "ctrl readback");
         chk(32'(er), 32'h0, "ctrl error");
         for (int k = 0; k < 5; k++)
            for (int d = 0; d < 4; d++)
               for (int j = 0; j < 3; j++)
                  run(k, 2'(d), (j == 0) ? 32'h0 : (j == 1) ? 32'h0001_0000 : $random(seed),
                      1'($random(seed)), 1'($random(seed)), (k < 4 && j == 2) ? 2 : 0);
      end
      run(0, 2'h0, 32'h8000_0000, 1'b1, 1'b0, 0);
      apb(1'b0, cbu_pkg::CBU_ADDR_STATUS, 32'h0);
      chk(rd, {16'h0, 8'(cnt), 6'h0, last_tk, 1'b0}, "status count");
      print_verdict;
   end
endmodule
